/* dv/smi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smi_host_model #(
   parameter int PRE = 8
) (
   input  wire logic mclk_in,      // system clock
   input  wire logic line_in,      // resolved data line
   output logic      mdc_out,      // management clock, low between frames
   output logic      data_out,     // host data
   output logic      data_oe_out   // host drives the data line
);
   initial begin
      mdc_out = 1'b0;
      data_out = 1'b1;
      data_oe_out = 1'b0;
   end

   // preamble then one 32-bit frame; read data sampled just before each rise
   task automatic xfer(input logic [31:0] f, input logic rd_op, output logic [15:0] q);
      int i;
      q = 16'h0000;
      for (i = 0; i < PRE + 32; i++) begin
         data_oe_out = !(rd_op && i >= PRE + 14);
         data_out = (i < PRE) ? 1'b1 : f[31 - (i - PRE)];
         repeat (3) @(negedge mclk_in);
         if (i >= PRE + 16)
            q = {q[14:0], line_in};
         mdc_out = 1'b1;
         repeat (3) @(negedge mclk_in);
         mdc_out = 1'b0;
      end
      data_oe_out = 1'b0;
      // one spare edge so a following frame never reassigns in this step
      @(negedge mclk_in);
   endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import phy_glue_pkg::*;
   localparam logic [15:0] ID_HI  = 16'h1c3e;  // arbitrary
   localparam logic [15:0] ID_LO  = 16'h3e1c;  // arbitrary
   localparam logic [4:0]  ADDR_A = 5'h0b;
   localparam logic [4:0]  ADDR_B = 5'h14;
   logic        mclk_in  = 1'b0;
   logic        reset_in = 1'b1;
   logic [4:0]  addr_set = ADDR_A;
   logic [2:0]  mode     = 3'h3;
   logic        mod_rst  = 1'b0;
   logic        seen     = 1'b0;
   logic        mdc, h_d, h_oe, d_out, d_dir, line, core_rst, sp, fd, an, pd;
   logic [4:0]  phy_addr;
   logic [10:0] scr;
   logic [8:0]  trim;
   logic [15:0] q;
   logic [3:0]  mode_tab [8] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'ha, 4'he, 4'h1, 4'he};
   int          n_errors  = 0;
   int          tests_run = 0;
   int          cyc       = 0;
   int          m;

   // pull-up when nobody drives the line
   assign line = d_dir ? d_out : (h_oe ? h_d : 1'b1);

   always #4 mclk_in = ~mclk_in;

   phy_glue_core #(.ID_HI_VAL(ID_HI), .ID_LO_VAL(ID_LO), .PREAMBLE_MIN(4)) dut (
      .mclk_in                 (mclk_in),
      .reset_in                (reset_in),
      .phy_address_setting_in  (addr_set),
      .block_op_mode_field_in  (mode),
      .module_reset_in         (mod_rst),
      .mgmt_serial_clock_in    (mdc),
      .mgmt_serial_in          (line),
      .mgmt_serial_out         (d_out),
      .mgmt_line_direction_out (d_dir),
      .phy_address_out         (phy_addr),
      .core_reset_out          (core_rst),
      .speed_100_out           (sp),
      .full_duplex_out         (fd),
      .autoneg_out             (an),
      .power_down_out          (pd),
      .scrambler_state_out     (scr),
      .tx_wave_trim_out        (trim)
   );

   smi_host_model #(.PRE(8)) host (
      .mclk_in     (mclk_in),
      .line_in     (line),
      .mdc_out     (mdc),
      .data_out    (h_d),
      .data_oe_out (h_oe)
   );

   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (core_rst === 1'b1)
         seen <= 1'b1;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic check_pin(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: port %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd);
      host.xfer({2'b01, op, pa, ra, 2'b10, wd}, op == OP_READ, q);
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      frame(OP_WRITE, addr_set, ra, wd);
   endtask

   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      frame(OP_READ, addr_set, ra, 16'h0000);
      check_reg(q, exp);
   endtask

   task automatic mreset(input logic [4:0] a);
      addr_set = a;
      mod_rst = 1'b1;
      repeat (3) @(negedge mclk_in);
      check_pin(core_rst, 1);
      check_pin(scr, {SEED_FILL, a});
      mod_rst = 1'b0;
      repeat (3) @(negedge mclk_in);
      check_pin(core_rst, 0);
      check_pin(phy_addr, a);
   endtask

   initial begin
      repeat (16) @(negedge mclk_in);
      reset_in = 1'b0;
      repeat (3) @(negedge mclk_in);
      check_pin(phy_addr, ADDR_A);
      check_pin(scr, {SEED_FILL, ADDR_A});
      addr_set = ADDR_B;
      repeat (5) @(negedge mclk_in);
      // exactly one x11+x9 step falls in these five cycles
      check_pin(scr, {SEED_FILL[4:0], ADDR_A, 1'b0});
      check_pin(phy_addr, ADDR_A);
      rd(REG_ID_HI, 16'hffff);
      addr_set = ADDR_A;
      rd(REG_TX_WAVE_ADJ, 16'h8000);
      rd(REG_ID_HI, ID_HI);
      rd(REG_ID_LO, ID_LO);
      wr(REG_TX_WAVE_ADJ, 16'h8055);
      rd(REG_TX_WAVE_ADJ, 16'h8000);
      wr(REG_MODE_CHANGE, 16'h0002);
      wr(REG_TX_WAVE_ADJ, 16'h8055);
      rd(REG_TX_WAVE_ADJ, 16'h8000);
      wr(REG_MODE_CHANGE, MODE_UNLOCK_KEY);
      rd(REG_MODE_CHANGE, 16'h0001);
      wr(REG_TX_WAVE_ADJ, 16'h8055);
      rd(REG_TX_WAVE_ADJ, 16'h8055);
      check_pin(trim, 9'h055);
      rd(REG_MODE_CHANGE, 16'h0000);
      wr(REG_TX_WAVE_ADJ, 16'h80aa);
      rd(REG_TX_WAVE_ADJ, 16'h8055);
      wr(REG_BASIC_CTRL, 16'h1234);
      rd(REG_BASIC_CTRL, 16'h1234);
      seen = 1'b0;
      wr(REG_BASIC_CTRL, 16'h8234);
      repeat (4) @(negedge mclk_in);
      check_pin(seen, 1);
      rd(REG_BASIC_CTRL, 16'h0000);
      rd(REG_TX_WAVE_ADJ, 16'h8000);
      mod_rst = 1'b1;
      wr(REG_BASIC_CTRL, 16'h0055);
      mod_rst = 1'b0;
      repeat (3) @(negedge mclk_in);
      rd(REG_BASIC_CTRL, 16'h0000);
      for (m = 0; m < 8; m++) begin
         mode = 3'(m);
         mreset(m[0] ? ADDR_B : ADDR_A);
         if (m == 6)
            check_pin(pd, 1);
         else
            check_pin({sp, fd, an, pd}, mode_tab[m]);
      end
      rd(REG_ID_LO, ID_LO);
      frame(OP_READ, ADDR_A, REG_ID_LO, 16'h0000);
      check_reg(q, 16'hffff);
      end_of_test();
   end
endmodule
`default_nettype wire

/* hdl/phy_glue_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - latch address on module or power-on reset
// - latched address seeds the transmit scrambler
// - mode field selects digital block configuration
// - register 0 bit 15 gives software reset
// - register 23 guarded against plain writes, unlocked by the key written to register 20
// - core runs at 25 MHz symbol rate
module phy_glue_core
   import phy_glue_pkg::*;
#(
   parameter logic [15:0] ID_HI_VAL    = 16'h0a5a,  // arbitrary identity value
   parameter logic [15:0] ID_LO_VAL    = 16'h5a0a,  // arbitrary identity value
   parameter int          PREAMBLE_MIN = 32
) (
   input  wire logic       mclk_in,                  // 125 MHz clock
   input  wire logic       reset_in,                 // power-on reset, async
   input  wire logic [4:0] phy_address_setting_in,   // address from control side
   input  wire logic [2:0] block_op_mode_field_in,   // mode from control side
   input  wire logic       module_reset_in,          // module reset bit level
   input  wire logic       mgmt_serial_clock_in,     // management clock
   input  wire logic       mgmt_serial_in,           // management data in
   output logic            mgmt_serial_out,          // management data out
   output logic            mgmt_line_direction_out,  // data line output enable
   output logic [4:0]      phy_address_out,          // latched address
   output logic            core_reset_out,           // core held in reset
   output logic            speed_100_out,            // 100 Mb/s selected
   output logic            full_duplex_out,          // full duplex selected
   output logic            autoneg_out,              // auto-negotiation enabled
   output logic            power_down_out,           // digital block powered down
   output logic [10:0]     scrambler_state_out,      // scrambler shift register
   output logic [8:0]      tx_wave_trim_out          // waveform trim field
);
   import phy_glue_pkg::*;

   if (MCLK_MHZ % PHY_CLK_MHZ != 0 || SYM_DIV_CYC < 2 || SYM_DIV_CYC > 8) begin : g_chk
      $error("phy_glue_core: clock ratio not supported");
   end

   typedef struct packed {
      logic [4:0]  phy_addr;
      logic        addr_valid;
      logic [3:0]  cfg;
      logic [14:0] bctrl;
      logic        soft_rst;
      logic        unlocked;
      logic [8:0]  wave;
      logic [10:0] lfsr;
      logic [2:0]  div;
      logic        core_rst;
   } core_s;

   // cfg = {power_down, autoneg, full_duplex, speed_100}
   function automatic logic [3:0] mode_cfg(input logic [2:0] m);
      case (m)
         3'h0:    mode_cfg = 4'h0;
         3'h1:    mode_cfg = 4'h2;
         3'h2:    mode_cfg = 4'h1;
         3'h3:    mode_cfg = 4'h3;
         3'h4:    mode_cfg = 4'h5;
         3'h5:    mode_cfg = 4'h7;
         3'h6:    mode_cfg = 4'h8;
         default: mode_cfg = 4'h7;
      endcase
   endfunction

   core_s st_ff;
   core_s nxt_st;
   smi_if bus ();
   logic  hold;
   logic  tick;
   logic  wr0;
   logic  wr20;
   logic  wr23;

   smi_frame #(
      .PREAMBLE_MIN (PREAMBLE_MIN)
   ) u_frame (
      .mclk_in                 (mclk_in),
      .reset_in                (reset_in),
      .mgmt_serial_clock_in    (mgmt_serial_clock_in),
      .mgmt_serial_in          (mgmt_serial_in),
      .mgmt_serial_out         (mgmt_serial_out),
      .mgmt_line_direction_out (mgmt_line_direction_out),
      .bus                     (bus.engine)
   );

   // module reset and the self-clearing soft reset both hold the core
   assign hold = module_reset_in | st_ff.soft_rst;
   assign tick = (st_ff.div == SYM_DIV_LAST);
   assign wr0  = bus.wr_stb && bus.reg_addr == REG_BASIC_CTRL;
   assign wr20 = bus.wr_stb && bus.reg_addr == REG_MODE_CHANGE;
   assign wr23 = bus.wr_stb && bus.reg_addr == REG_TX_WAVE_ADJ;

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.soft_rst = 1'b0;
      nxt_st.core_rst = hold;
      nxt_st.div      = tick ? 3'h0 : st_ff.div + 3'h1;
      if (tick) begin
         nxt_st.lfsr = {st_ff.lfsr[9:0], st_ff.lfsr[10] ^ st_ff.lfsr[8]};
      end
      if (hold || !st_ff.addr_valid) begin
         // capture runs through the whole reset, so the value at release sticks
         nxt_st.phy_addr   = phy_address_setting_in;
         nxt_st.addr_valid = 1'b1;
         nxt_st.cfg        = mode_cfg(block_op_mode_field_in);
         nxt_st.lfsr       = {SEED_FILL, phy_address_setting_in};
         nxt_st.bctrl      = BC_RESET_VAL;
         nxt_st.unlocked   = 1'b0;
         nxt_st.wave       = WAVE_RESET_VAL;
      end else if (bus.wr_stb) begin
         // any write other than the key relocks the guarded register 23
         nxt_st.unlocked = wr20 && bus.wr_data == MODE_UNLOCK_KEY;
         if (wr0) begin
            nxt_st.bctrl    = bus.wr_data[14:0];
            nxt_st.soft_rst = bus.wr_data[BC_SOFT_RESET];
         end
         if (wr23 && st_ff.unlocked) begin
            nxt_st.wave = bus.wr_data[8:0];
         end
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // soft reset bit always reads back as zero: it clears itself
   always_comb begin
      case (bus.reg_addr)
         REG_BASIC_CTRL:  bus.rd_data = {1'b0, st_ff.bctrl};
         REG_ID_HI:       bus.rd_data = ID_HI_VAL;
         REG_ID_LO:       bus.rd_data = ID_LO_VAL;
         REG_MODE_CHANGE: bus.rd_data = {15'h0000, st_ff.unlocked};
         REG_TX_WAVE_ADJ: bus.rd_data = {1'b1, 6'h00, st_ff.wave};
         default:         bus.rd_data = 16'h0000;
      endcase
   end

   assign bus.phy_addr        = st_ff.phy_addr;
   assign phy_address_out     = st_ff.phy_addr;
   assign core_reset_out      = st_ff.core_rst;
   assign speed_100_out       = st_ff.cfg[0];
   assign full_duplex_out     = st_ff.cfg[1];
   assign autoneg_out         = st_ff.cfg[2];
   assign power_down_out      = st_ff.cfg[3];
   assign scrambler_state_out = st_ff.lfsr;
   assign tx_wave_trim_out    = st_ff.wave;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   sequence s_soft_pulse;
      st_ff.soft_rst ##1 !st_ff.soft_rst && st_ff.core_rst;
   endsequence

   sequence s_sym_period;
      !tick [*4] ##1 tick;
   endsequence

   a_addr_latch: assert property (module_reset_in |=> st_ff.phy_addr == $past(phy_address_setting_in))
      else $error("address not captured during module reset");
   a_addr_hold: assert property (!hold && st_ff.addr_valid |=> $stable(st_ff.phy_addr))
      else $error("address changed outside reset");
   a_seed_load: assert property (hold |=> st_ff.lfsr == {SEED_FILL, $past(phy_address_setting_in)})
      else $error("scrambler not seeded from the address");
   a_mode_select: assert property (module_reset_in |=> st_ff.cfg == mode_cfg($past(block_op_mode_field_in)))
      else $error("mode field not applied");
   a_soft_reset: assert property (wr0 && bus.wr_data[15] && !hold |=> s_soft_pulse)
      else $error("soft reset not a single pulse into core reset");
   a_wave_guard: assert property (wr23 && !st_ff.unlocked && !hold |=> $stable(st_ff.wave))
      else $error("guarded register changed without key");
   a_sym_rate: assert property (tick |=> s_sym_period)
      else $error("symbol tick not at 25 MHz");
   a_hold_reset: assert property (module_reset_in |=> core_reset_out && st_ff.wave == WAVE_RESET_VAL)
      else $error("core not held while module reset set");
   a_wave_fixed: assert property (bus.reg_addr == REG_TX_WAVE_ADJ |-> bus.rd_data[15:9] == 7'h40)
      else $error("waveform fixed bits read wrong");
endmodule
`default_nettype wire

/* hdl/phy_glue_pkg.sv */
package phy_glue_pkg;

   // clocking: 125 MHz system clock and the 25 MHz symbol rate of the core
   localparam int          MCLK_MHZ        = 125;
   localparam int          PHY_CLK_MHZ     = 25;
   localparam int          SYM_DIV_CYC     = MCLK_MHZ / PHY_CLK_MHZ;
   localparam logic [2:0]  SYM_DIV_LAST    = 3'(SYM_DIV_CYC - 1);

   // management register numbers
   localparam logic [4:0]  REG_BASIC_CTRL  = 5'h00;
   localparam logic [4:0]  REG_ID_HI       = 5'h02;
   localparam logic [4:0]  REG_ID_LO       = 5'h03;
   localparam logic [4:0]  REG_MODE_CHANGE = 5'h14;
   localparam logic [4:0]  REG_TX_WAVE_ADJ = 5'h17;

   // field positions and reset values
   localparam int          BC_SOFT_RESET   = 15;
   localparam logic [14:0] BC_RESET_VAL    = 15'h0000;
   localparam int          WAVE_FIXED_ONE  = 15;
   localparam int          WAVE_ZERO_MSB   = 14;
   localparam int          WAVE_ZERO_LSB   = 9;
   localparam logic [8:0]  WAVE_RESET_VAL  = 9'h000;
   localparam logic [15:0] MODE_UNLOCK_KEY = 16'h0001;
   localparam logic [5:0]  SEED_FILL       = 6'h3f;

   // serial management frame
   localparam logic [5:0]  PREAMBLE_ONES   = 6'h20;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [3:0]  HDR_LAST        = 4'hb;
   localparam logic [3:0]  DATA_LAST       = 4'hf;

   typedef enum logic [2:0] {FR_IDLE, FR_START, FR_HDR, FR_TA, FR_DATA} frame_state_e;

endpackage

/* hdl/smi_frame.sv */
`timescale 1ns/1ps
`default_nettype none
module smi_frame
   import phy_glue_pkg::*;
#(
   parameter int PREAMBLE_MIN = 32
) (
   input  wire logic mclk_in,                  // system clock
   input  wire logic reset_in,                 // async reset, active high
   input  wire logic mgmt_serial_clock_in,     // management clock, sampled
   input  wire logic mgmt_serial_in,           // management data in
   output logic      mgmt_serial_out,          // management data out
   output logic      mgmt_line_direction_out,  // high while driving data
   smi_if.engine     bus                       // register side
);
   import phy_glue_pkg::*;

   if (PREAMBLE_MIN < 1 || PREAMBLE_MIN > 63) begin : g_chk
      $error("smi_frame: PREAMBLE_MIN out of range");
   end

   typedef struct packed {
      logic         mdc_q;
      frame_state_e st;
      logic [5:0]   ones;
      logic [3:0]   cnt;
      logic [11:0]  hdr;
      logic [15:0]  data;
      logic         rd;
      logic         hit;
      logic         dout;
      logic         dir;
      logic         wr;
   } frame_s;

   frame_s st_ff;
   frame_s nxt_st;
   logic   rise;

   assign rise = mgmt_serial_clock_in & ~st_ff.mdc_q;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.mdc_q = mgmt_serial_clock_in;
      nxt_st.wr    = 1'b0;
      if (rise) begin
         case (st_ff.st)
            FR_IDLE: begin
               if (mgmt_serial_in) begin
                  if (st_ff.ones != 6'h3f) nxt_st.ones = st_ff.ones + 6'h01;
               end else begin
                  if (st_ff.ones >= 6'(PREAMBLE_MIN)) nxt_st.st = FR_START;
                  nxt_st.ones = 6'h00;
               end
            end
            FR_START: begin
               nxt_st.st  = mgmt_serial_in ? FR_HDR : FR_IDLE;
               nxt_st.cnt = 4'h0;
            end
            FR_HDR: begin
               nxt_st.hdr = {st_ff.hdr[10:0], mgmt_serial_in};
               nxt_st.cnt = st_ff.cnt + 4'h1;
               // twelve header bits: op, phy address, register number
               if (st_ff.cnt == HDR_LAST) begin
                  // only frames to our own latched address are answered
                  nxt_st.hit = (nxt_st.hdr[9:5] == bus.phy_addr);
                  nxt_st.rd  = (nxt_st.hdr[11:10] == OP_READ);
                  nxt_st.cnt = 4'h0;
                  nxt_st.st  = (nxt_st.hdr[11:10] == OP_READ || nxt_st.hdr[11:10] == OP_WRITE) ? FR_TA : FR_IDLE;
               end
            end
            FR_TA: begin
               nxt_st.cnt = st_ff.cnt + 4'h1;
               if (st_ff.cnt == 4'h0 && st_ff.rd && st_ff.hit) begin
                  nxt_st.dir  = 1'b1;
                  nxt_st.dout = 1'b0;
               end
               if (st_ff.cnt == 4'h1) begin
                  nxt_st.cnt  = 4'h0;
                  nxt_st.st   = FR_DATA;
                  nxt_st.data = bus.rd_data;
                  nxt_st.dout = bus.rd_data[15];
               end
            end
            FR_DATA: begin
               nxt_st.cnt = st_ff.cnt + 4'h1;
               if (st_ff.rd) begin
                  nxt_st.data = {st_ff.data[14:0], 1'b0};
                  nxt_st.dout = st_ff.data[14];
               end else begin
                  nxt_st.data = {st_ff.data[14:0], mgmt_serial_in};
               end
               if (st_ff.cnt == DATA_LAST) begin
                  nxt_st.wr   = ~st_ff.rd & st_ff.hit;
                  nxt_st.dir  = 1'b0;
                  nxt_st.dout = 1'b0;
                  nxt_st.ones = 6'h00;
                  nxt_st.st   = FR_IDLE;
               end
            end
            default: nxt_st.st = FR_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus.reg_addr            = st_ff.hdr[4:0];
   assign bus.wr_stb              = st_ff.wr;
   assign bus.wr_data             = st_ff.data;
   assign mgmt_serial_out         = st_ff.dout;
   assign mgmt_line_direction_out = st_ff.dir;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   a_drive_only_hit: assert property ($rose(st_ff.dir) |-> $past(st_ff.rd && st_ff.hit) && !st_ff.dout)
      else $error("data line driven for a frame not addressed here");
   a_write_one_shot: assert property (st_ff.wr |=> !st_ff.wr && st_ff.st == FR_IDLE)
      else $error("write strobe longer than one cycle");
   a_no_drive_write: assert property (st_ff.st == FR_DATA && !st_ff.rd |-> !st_ff.dir)
      else $error("data line driven during a write frame");
endmodule
`default_nettype wire

/* hdl/smi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface smi_if;
   logic [4:0]  reg_addr;   // register number of the current frame
   logic        wr_stb;     // one-cycle write pulse
   logic [15:0] wr_data;    // write data, valid with wr_stb
   logic [15:0] rd_data;    // read data for reg_addr
   logic [4:0]  phy_addr;   // latched own address

   modport engine (output reg_addr, output wr_stb, output wr_data, input rd_data, input phy_addr);
   modport regs   (input reg_addr, input wr_stb, input wr_data, output rd_data, output phy_addr);
endinterface
`default_nettype wire
